// ### rtl/pmrb_pkg.sv
// Notes on behaviour
// RULE1 - registers are 16 bits, moved on the link as two 8-bit bytes
// RULE2 - pointer 00h holds the read/write operating setup, power-on value 4127h
// RULE3 - pointer 01h is the read-only sense voltage result, reset zero
// RULE4 - pointer 02h is the read-only rail voltage result, reset zero
// RULE5 - pointers 03h power and 04h current are read-only results, reset zero
// RULE6 - current and power read zero while the scaling value is zero; the code zeroes them only when a conversion completes with scale zero
// RULE7 - pointer 05h is the read/write scaling value, reset zero
// RULE8 - pointer 06h holds alert selection and conversion-ready flag, reset zero
// RULE9 - pointer 07h is the read/write alert threshold, reset zero
// RULE10 - pointers FEh and FFh return fixed maker and die codes
// RULE11 - reading the setup register disturbs neither settings nor conversions
// RULE12 - writing setup halts conversion until done, then restarts with new settings
// RULE13 - setup bit 15 written one resets all registers and self-clears
// RULE14 - bits 11:9 pick 1,4,16,64,128,256,512,1024 averaged samples
// RULE15 - bits 8:6 pick rail conversion time, 140 us to 8.244 ms, default 100
// RULE16 - bits 5:3 pick sense conversion time with the same table, default 100
// RULE17 - bits 2:0 pick power-down, triggered or continuous sense/rail/both
// RULE18 - a write carries a pointer byte; reads use the last pointer written
// RULE19 - words travel most significant byte first
// RULE20 - writes to read-only or unmapped pointers change nothing
package pmrb_pkg;

    localparam logic [7:0] PTR_SETUP = 8'h00;
    localparam logic [7:0] PTR_SENSE = 8'h01;
    localparam logic [7:0] PTR_RAIL = 8'h02;
    localparam logic [7:0] PTR_POWER = 8'h03;
    localparam logic [7:0] PTR_CURRENT = 8'h04;
    localparam logic [7:0] PTR_SCALE = 8'h05;
    localparam logic [7:0] PTR_ALERT_SEL = 8'h06;
    localparam logic [7:0] PTR_LIMIT = 8'h07;
    localparam logic [7:0] PTR_MAKER = 8'hFE;
    localparam logic [7:0] PTR_DIE = 8'hFF;

    localparam logic [15:0] SETUP_RESET = 16'h4127;
    localparam logic [15:0] ZERO_RESET = 16'h0000;
    // only the selection bits and the two low bits of pointer 06h are writable
    localparam logic [15:0] ALERT_SEL_WMASK = 16'hFC03;

    localparam int SETUP_RST_BIT = 15;
    localparam int AVG_LSB = 9;
    localparam int RAIL_CT_LSB = 6;
    localparam int SENSE_CT_LSB = 3;
    localparam int MODE_LSB = 0;
    localparam int READY_BIT = 3;
    localparam int MODE_CONT_BIT = 2;
    localparam int MODE_RAIL_BIT = 1;
    localparam int MODE_SENSE_BIT = 0;

    // log2 of the averaged sample counts
    localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};

    localparam int MCLK_NS = 8;
    localparam int CT_NS [8] = '{140000, 204000, 332000, 588000, 1100000, 2116000, 4156000, 8244000};
    localparam int CT_CYC [8] = '{CT_NS[0] / MCLK_NS, CT_NS[1] / MCLK_NS, CT_NS[2] / MCLK_NS,
        CT_NS[3] / MCLK_NS, CT_NS[4] / MCLK_NS, CT_NS[5] / MCLK_NS, CT_NS[6] / MCLK_NS, CT_NS[7] / MCLK_NS};

    localparam int CAL_SHIFT = 11;
    localparam int POWER_DIV = 20000;

    typedef enum logic [1:0] {
        PMRB_IDLE = 2'b00,
        PMRB_SENSE = 2'b01,
        PMRB_RAIL = 2'b11,
        PMRB_DONE = 2'b10
    } pmrb_conv_t;

endpackage

// ### rtl/pmrb_bank.sv
`timescale 1ns/100ps
`default_nettype none
module pmrb_bank #(
    parameter logic [15:0] MAKER_CODE = 16'hA5C3, // arbitrary value
    parameter logic [15:0] DIE_CODE = 16'h0C10, // arbitrary value
    parameter int CONV_CYC [8] = pmrb_pkg::CT_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [15:0] sense_sample,
    input wire logic [15:0] rail_sample,
    output logic [15:0] setup_word,
    output logic [15:0] alert_sel_word,
    output logic [15:0] alert_limit_word,
    output logic conv_busy,
    input wire logic link_clk,
    input wire logic lk_wr_start,
    input wire logic lk_rx_valid,
    input wire logic [7:0] lk_rx_byte,
    input wire logic lk_rd_start,
    input wire logic lk_tx_take,
    input wire logic lk_stop,
    output logic [7:0] lk_tx_byte,
    output logic lk_tx_ready
);

    typedef struct packed {
        logic [15:0] setup;
        logic [15:0] scale;
        logic [15:0] alert_sel;
        logic [15:0] limit;
        logic ready;
        logic [15:0] sense_res;
        logic [15:0] rail_res;
        logic [15:0] cur_res;
        logic [15:0] pwr_res;
        logic calc;
        pmrb_pkg::pmrb_conv_t st;
        logic [20:0] timer;
        logic [10:0] samp_cnt;
        logic signed [25:0] acc_s;
        logic [25:0] acc_r;
        logic [2:0] wr_s;
        logic [2:0] rd_s;
        logic [1:0] hold_s;
        logic [15:0] rd_word;
        logic rd_ack;
        logic busy;
        logic stalled;
    } pmrb_m_t;

    typedef struct packed {
        logic [1:0] rst_s;
        logic [7:0] ptr;
        logic [1:0] idx;
        logic wr_txn;
        logic hold;
        logic [7:0] wr_ptr;
        logic [15:0] wr_data;
        logic [7:0] msb;
        logic wr_tgl;
        logic rd_tgl;
        logic [2:0] ack_s;
        logic [7:0] tx_byte;
        logic [7:0] tx_lsb;
        logic tx_ready;
        logic sel;
    } pmrb_l_t;

    pmrb_m_t m_q;
    pmrb_m_t m_d;
    pmrb_l_t l_q;
    pmrb_l_t l_d;

    function automatic logic [20:0] conv_cycles(input logic [2:0] code);
        conv_cycles = 21'(CONV_CYC[code]);
    endfunction

    function automatic logic [15:0] reg_word(input pmrb_m_t s, input logic [7:0] ptr);
        case (ptr)
            pmrb_pkg::PTR_SETUP: reg_word = s.setup; // [RULE2] [RULE11]
            pmrb_pkg::PTR_SENSE: reg_word = s.sense_res; // [RULE3]
            pmrb_pkg::PTR_RAIL: reg_word = s.rail_res; // [RULE4]
            pmrb_pkg::PTR_POWER: reg_word = s.pwr_res; // [RULE5]
            pmrb_pkg::PTR_CURRENT: reg_word = s.cur_res; // [RULE5]
            pmrb_pkg::PTR_SCALE: reg_word = s.scale; // [RULE7]
            pmrb_pkg::PTR_ALERT_SEL: reg_word = s.alert_sel | (16'(s.ready) << pmrb_pkg::READY_BIT); // [RULE8]
            pmrb_pkg::PTR_LIMIT: reg_word = s.limit; // [RULE9]
            pmrb_pkg::PTR_MAKER: reg_word = MAKER_CODE; // [RULE10]
            pmrb_pkg::PTR_DIE: reg_word = DIE_CODE; // [RULE10]
            default: reg_word = 16'h0000;
        endcase
    endfunction

    // main clock domain: register file, conversion sequencer, result arithmetic
    logic wr_evt;
    logic rd_evt;
    logic halted;
    logic [2:0] mode;
    logic [3:0] shift;
    logic [10:0] last_samp;
    logic start_conv;
    logic signed [31:0] cur_prod;
    logic [31:0] cur_mag;
    logic [47:0] pwr_prod;
    logic signed [31:0] sense_ext;
    logic signed [31:0] scale_ext;

    always_comb begin
        m_d = m_q;
        wr_evt = m_q.wr_s[1] ^ m_q.wr_s[2];
        rd_evt = m_q.rd_s[1] ^ m_q.rd_s[2];
        halted = m_q.hold_s[1];
        mode = m_q.setup[pmrb_pkg::MODE_LSB +: 3];
        shift = pmrb_pkg::AVG_SHIFT[m_q.setup[pmrb_pkg::AVG_LSB +: 3]]; // [RULE14]
        last_samp = 11'((12'h001 << shift) - 12'h001);
        start_conv = 1'b0;
        // both factors are widened first so the product cannot be cut to 16 bits
        sense_ext = 32'($signed(m_q.sense_res));
        scale_ext = $signed({16'h0000, m_q.scale});
        cur_prod = (sense_ext * scale_ext) >>> pmrb_pkg::CAL_SHIFT;
        cur_mag = cur_prod[31] ? 32'(-cur_prod) : 32'(cur_prod);
        pwr_prod = 48'(cur_mag) * 48'(m_q.rail_res) / 48'(pmrb_pkg::POWER_DIV);

        m_d.wr_s = {m_q.wr_s[1:0], l_q.wr_tgl};
        m_d.rd_s = {m_q.rd_s[1:0], l_q.rd_tgl};
        m_d.hold_s = {m_q.hold_s[0], l_q.hold};

        // read fetch: snapshot the pointed word and hand it back by toggle
        if (rd_evt) begin
            m_d.rd_word = reg_word(m_q, l_q.ptr); // [RULE11]
            m_d.rd_ack = ~m_q.rd_ack;
            if (l_q.ptr == pmrb_pkg::PTR_ALERT_SEL) begin
                m_d.ready = 1'b0;
            end
        end

        // conversion sequencer
        case (m_q.st)
            pmrb_pkg::PMRB_IDLE: begin
            end
            pmrb_pkg::PMRB_SENSE: begin
                if (m_q.timer == 21'h000000) begin
                    m_d.acc_s = m_q.acc_s + 26'($signed(sense_sample));
                    if (mode[pmrb_pkg::MODE_RAIL_BIT]) begin
                        m_d.st = pmrb_pkg::PMRB_RAIL;
                        m_d.timer = conv_cycles(m_q.setup[pmrb_pkg::RAIL_CT_LSB +: 3]) - 21'h000001; // [RULE15]
                    end else begin
                        m_d.st = pmrb_pkg::PMRB_DONE;
                    end
                end else begin
                    m_d.timer = m_q.timer - 21'h000001;
                end
            end
            pmrb_pkg::PMRB_RAIL: begin
                if (m_q.timer == 21'h000000) begin
                    m_d.acc_r = m_q.acc_r + 26'(rail_sample);
                    m_d.st = pmrb_pkg::PMRB_DONE;
                end else begin
                    m_d.timer = m_q.timer - 21'h000001;
                end
            end
            pmrb_pkg::PMRB_DONE: begin
                if (m_q.samp_cnt == last_samp) begin
                    // averaged results replace the old ones only for the measured channels
                    if (mode[pmrb_pkg::MODE_SENSE_BIT]) begin
                        m_d.sense_res = 16'(m_q.acc_s >>> shift);
                    end
                    if (mode[pmrb_pkg::MODE_RAIL_BIT]) begin
                        m_d.rail_res = 16'(m_q.acc_r >> shift);
                    end
                    m_d.calc = 1'b1;
                    m_d.ready = 1'b1;
                    m_d.samp_cnt = 11'h000;
                    m_d.acc_s = 26'sh0000000;
                    m_d.acc_r = 26'h0000000;
                    m_d.st = pmrb_pkg::PMRB_IDLE;
                    start_conv = mode[pmrb_pkg::MODE_CONT_BIT]; // [RULE17]
                end else begin
                    m_d.samp_cnt = m_q.samp_cnt + 11'h001;
                    m_d.st = pmrb_pkg::PMRB_IDLE;
                    start_conv = 1'b1;
                end
            end
            default: begin
                m_d.st = pmrb_pkg::PMRB_IDLE;
            end
        endcase

        // derived results follow the averaged ones by one cycle
        if (m_q.calc) begin
            m_d.calc = 1'b0;
            if (m_q.scale == 16'h0000) begin
                m_d.cur_res = 16'h0000; // [RULE6]
                m_d.pwr_res = 16'h0000; // [RULE6]
            end else begin
                m_d.cur_res = 16'(cur_prod);
                m_d.pwr_res = 16'(pwr_prod);
            end
        end

        // a setup write in flight freezes the sequencer and drops the partial average
        if (halted) begin
            m_d.st = pmrb_pkg::PMRB_IDLE; // [RULE12]
            m_d.stalled = 1'b1;
            m_d.samp_cnt = 11'h000;
            m_d.acc_s = 26'sh0000000;
            m_d.acc_r = 26'h0000000;
            start_conv = 1'b0;
        end

        // register writes from the link
        if (wr_evt) begin
            case (l_q.wr_ptr)
                pmrb_pkg::PTR_SETUP: begin
                    m_d.setup = l_q.wr_data & ~(16'h0001 << pmrb_pkg::SETUP_RST_BIT);
                    m_d.ready = 1'b0;
                    m_d.st = pmrb_pkg::PMRB_IDLE;
                    m_d.samp_cnt = 11'h000;
                    m_d.acc_s = 26'sh0000000;
                    m_d.acc_r = 26'h0000000;
                    start_conv = 1'b1; // [RULE12]
                end
                pmrb_pkg::PTR_SCALE: m_d.scale = l_q.wr_data; // [RULE7]
                pmrb_pkg::PTR_ALERT_SEL: begin
                    m_d.alert_sel = l_q.wr_data & pmrb_pkg::ALERT_SEL_WMASK; // [RULE8]
                end
                pmrb_pkg::PTR_LIMIT: m_d.limit = l_q.wr_data; // [RULE9]
                default: begin // [RULE20]
                end
            endcase
        end

        // the ready flag set by a finishing conversion outlives a same-cycle read clear
        if (m_q.st == pmrb_pkg::PMRB_DONE && m_q.samp_cnt == last_samp && !halted && !wr_evt) begin
            m_d.ready = 1'b1;
        end

        // a setup write cut off before its low byte leaves the old settings running again
        if (m_q.stalled && !halted) begin
            m_d.stalled = 1'b0;
            start_conv = 1'b1; // [RULE12]
        end

        // m_d.setup already holds a setup word written this cycle, and only such a word
        if (start_conv) begin
            case (m_d.setup[pmrb_pkg::MODE_LSB +: 2])
                2'b01, 2'b11: begin
                    m_d.st = pmrb_pkg::PMRB_SENSE;
                    m_d.timer = conv_cycles(m_d.setup[pmrb_pkg::SENSE_CT_LSB +: 3]) - 21'h000001; // [RULE16]
                end
                2'b10: begin
                    m_d.st = pmrb_pkg::PMRB_RAIL;
                    m_d.timer = conv_cycles(m_d.setup[pmrb_pkg::RAIL_CT_LSB +: 3]) - 21'h000001; // [RULE15]
                end
                default: m_d.st = pmrb_pkg::PMRB_IDLE; // [RULE17]
            endcase
        end

        // soft reset keeps the crossing state so toggles stay aligned
        if (wr_evt && l_q.wr_ptr == pmrb_pkg::PTR_SETUP && l_q.wr_data[pmrb_pkg::SETUP_RST_BIT]) begin
            m_d.setup = pmrb_pkg::SETUP_RESET; // [RULE13]
            m_d.scale = pmrb_pkg::ZERO_RESET;
            m_d.alert_sel = pmrb_pkg::ZERO_RESET;
            m_d.limit = pmrb_pkg::ZERO_RESET;
            m_d.ready = 1'b0;
            m_d.sense_res = pmrb_pkg::ZERO_RESET;
            m_d.rail_res = pmrb_pkg::ZERO_RESET;
            m_d.cur_res = pmrb_pkg::ZERO_RESET;
            m_d.pwr_res = pmrb_pkg::ZERO_RESET;
            m_d.calc = 1'b0;
            m_d.st = pmrb_pkg::PMRB_SENSE;
            m_d.timer = conv_cycles(pmrb_pkg::SETUP_RESET[pmrb_pkg::SENSE_CT_LSB +: 3]) - 21'h000001;
            m_d.samp_cnt = 11'h000;
            m_d.acc_s = 26'sh0000000;
            m_d.acc_r = 26'h0000000;
        end

        // busy is kept in a flop of its own so the port needs no decode
        m_d.busy = m_d.st == pmrb_pkg::PMRB_SENSE || m_d.st == pmrb_pkg::PMRB_RAIL;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            m_q <= '0;
            m_q.busy <= 1'b1;
            m_q.setup <= pmrb_pkg::SETUP_RESET; // [RULE2]
            m_q.st <= pmrb_pkg::PMRB_SENSE;
            m_q.timer <= conv_cycles(pmrb_pkg::SETUP_RESET[pmrb_pkg::SENSE_CT_LSB +: 3]) - 21'h000001;
        end else begin
            m_q <= m_d;
        end
    end

    assign setup_word = m_q.setup;
    assign alert_sel_word = m_q.alert_sel;
    assign alert_limit_word = m_q.limit;
    assign conv_busy = m_q.busy;

    // link clock domain: pointer, byte pairing, read byte server
    logic ack_evt;

    always_comb begin
        l_d = l_q;
        l_d.rst_s = {l_q.rst_s[0], 1'b1};
        l_d.ack_s = {l_q.ack_s[1:0], m_q.rd_ack};
        ack_evt = l_q.ack_s[1] ^ l_q.ack_s[2];

        if (lk_wr_start) begin
            l_d.wr_txn = 1'b1;
            l_d.idx = 2'h0;
        end else if (lk_rx_valid && l_q.wr_txn) begin
            case (l_q.idx)
                2'h0: begin
                    l_d.ptr = lk_rx_byte; // [RULE18]
                    l_d.idx = 2'h1;
                end
                2'h1: begin
                    // halting waits for data so that a pointer-only write disturbs nothing
                    l_d.hold = l_q.ptr == pmrb_pkg::PTR_SETUP; // [RULE11] [RULE12]
                    l_d.msb = lk_rx_byte; // [RULE19]
                    l_d.idx = 2'h2;
                end
                2'h2: begin
                    l_d.wr_ptr = l_q.ptr;
                    l_d.wr_data = {l_q.msb, lk_rx_byte}; // [RULE1] [RULE19]
                    l_d.wr_tgl = ~l_q.wr_tgl;
                    l_d.hold = 1'b0;
                    l_d.idx = 2'h3;
                end
                default: begin
                end
            endcase
        end
        if (lk_stop) begin
            l_d.wr_txn = 1'b0;
            l_d.hold = 1'b0;
        end

        if (lk_rd_start) begin
            l_d.wr_txn = 1'b0;
            l_d.rd_tgl = ~l_q.rd_tgl; // [RULE18]
            l_d.tx_ready = 1'b0;
        end else if (ack_evt) begin
            l_d.tx_byte = m_q.rd_word[15:8]; // [RULE19]
            l_d.tx_lsb = m_q.rd_word[7:0];
            l_d.tx_ready = 1'b1;
            l_d.sel = 1'b0;
        end else if (lk_tx_take && l_q.tx_ready) begin
            // bytes beyond the second repeat the low byte
            l_d.tx_byte = l_q.tx_lsb; // [RULE1]
            l_d.sel = 1'b1;
        end

        if (!l_q.rst_s[1]) begin
            l_d = '0;
            l_d.rst_s = {l_q.rst_s[0], 1'b1};
            l_d.ack_s = {l_q.ack_s[1:0], m_q.rd_ack};
        end
    end

    always_ff @(posedge link_clk) begin
        if (!rst_n) begin
            l_q.rst_s <= 2'b00;
            l_q[$bits(pmrb_l_t)-3:0] <= l_d[$bits(pmrb_l_t)-3:0];
        end else begin
            l_q <= l_d;
        end
    end

    assign lk_tx_byte = l_q.tx_byte;
    assign lk_tx_ready = l_q.tx_ready;

endmodule // pmrb_bank
`default_nettype wire

// ### dv/pmrb_bank_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module pmrb_bank_asserts (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [15:0] sense_sample,
    input wire logic [15:0] rail_sample,
    input wire logic [15:0] setup_word,
    input wire logic [15:0] alert_sel_word,
    input wire logic [15:0] alert_limit_word,
    input wire logic conv_busy,
    input wire logic link_clk,
    input wire logic lk_wr_start,
    input wire logic lk_rx_valid,
    input wire logic [7:0] lk_rx_byte,
    input wire logic lk_rd_start,
    input wire logic lk_tx_take,
    input wire logic lk_stop,
    input wire logic [7:0] lk_tx_byte,
    input wire logic lk_tx_ready
);
    // the fetch crosses into mclk and back, so the answer is a few link edges late
    sequence s_fetch;
        ##[2:6] lk_tx_ready;
    endsequence
    property p_reset_vals;
        @(posedge mclk) !rst_n |=> setup_word == pmrb_pkg::SETUP_RESET && alert_sel_word == 16'h0000
            && alert_limit_word == 16'h0000;
    endproperty
    property p_rst_bit_clear;
        @(posedge mclk) disable iff (!rst_n) setup_word[15] == 1'b0;
    endproperty
    property p_alert_mask;
        @(posedge mclk) disable iff (!rst_n) (alert_sel_word & ~pmrb_pkg::ALERT_SEL_WMASK) == 16'h0000;
    endproperty
    property p_idle_mode;
        @(posedge mclk) disable iff (!rst_n) (setup_word[1:0] == 2'b00) [*4] |-> !conv_busy;
    endproperty
    property p_restart;
        @(posedge mclk) disable iff (!rst_n) $changed(setup_word) && setup_word[1:0] != 2'b00
            |-> ##[0:4] conv_busy;
    endproperty
    property p_ready_drop;
        @(posedge link_clk) disable iff (!rst_n) lk_rd_start |=> !lk_tx_ready;
    endproperty
    property p_fetch;
        @(posedge link_clk) disable iff (!rst_n) lk_rd_start |-> s_fetch;
    endproperty
    property p_tx_hold;
        @(posedge link_clk) disable iff (!rst_n) lk_tx_ready && !lk_tx_take && !lk_rd_start
            |=> $stable(lk_tx_byte);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
    a_rst_bit_clear: assert property (p_rst_bit_clear) else $error("reset bit not clear");
    a_alert_mask: assert property (p_alert_mask) else $error("alert select bits");
    a_idle_mode: assert property (p_idle_mode) else $error("busy in power-down");
    a_restart: assert property (p_restart) else $error("no restart after setup write");
    a_ready_drop: assert property (p_ready_drop) else $error("ready kept on new read");
    a_fetch: assert property (p_fetch) else $error("read word late");
    a_tx_hold: assert property (p_tx_hold) else $error("tx byte moved");
endmodule // pmrb_bank_asserts
bind pmrb_bank pmrb_bank_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .sense_sample(sense_sample),
    .rail_sample(rail_sample), .setup_word(setup_word), .alert_sel_word(alert_sel_word),
    .alert_limit_word(alert_limit_word), .conv_busy(conv_busy), .link_clk(link_clk),
    .lk_wr_start(lk_wr_start), .lk_rx_valid(lk_rx_valid), .lk_rx_byte(lk_rx_byte),
    .lk_rd_start(lk_rd_start), .lk_tx_take(lk_tx_take), .lk_stop(lk_stop), .lk_tx_byte(lk_tx_byte),
    .lk_tx_ready(lk_tx_ready));
`default_nettype wire

// ### dv/pmrb_link_master.sv
`timescale 1ns/100ps
`default_nettype none
module pmrb_link_master (
    output logic link_clk,
    output logic lk_wr_start,
    output logic lk_rx_valid,
    output logic [7:0] lk_rx_byte,
    output logic lk_rd_start,
    output logic lk_tx_take,
    output logic lk_stop,
    input wire logic [7:0] lk_tx_byte,
    input wire logic lk_tx_ready
);
    bit hung = 1'b0;
    initial begin
        {link_clk, lk_wr_start, lk_rx_valid, lk_rd_start, lk_tx_take, lk_stop} = '0;
        lk_rx_byte = 8'h00;
    end
    // clock runs only inside tasks, so it stands still between frames
    task automatic cyc(input int n);
        repeat (n) begin
            #80 link_clk = 1'b1;
            #80 link_clk = 1'b0;
        end
    endtask
    // valid stays up across back-to-back bytes; the frame task drops it once
    task automatic send(input logic [7:0] b);
        lk_rx_byte = b;
        lk_rx_valid = 1'b1;
        cyc(1);
    endtask
    task automatic stop_frame();
        lk_stop = 1'b1;
        cyc(1);
        lk_stop = 1'b0;
        cyc(1);
    endtask
    task automatic wr_word(input logic [7:0] p, input logic [15:0] d, input bit ptr_only);
        lk_wr_start = 1'b1;
        cyc(1);
        lk_wr_start = 1'b0;
        send(p);
        if (!ptr_only) begin
            send(d[15:8]);
            send(d[7:0]);
        end
        lk_rx_valid = 1'b0;
        // idle data shows the inverse so a stale byte cannot pass
        lk_rx_byte = ~lk_rx_byte;
        stop_frame();
    endtask
    task automatic rd_word(output logic [15:0] d);
        int i;
        lk_rd_start = 1'b1;
        cyc(1);
        lk_rd_start = 1'b0;
        for (i = 0; i < 12 && lk_tx_ready !== 1'b1; i++) cyc(1);
        hung = (lk_tx_ready !== 1'b1);
        d[15:8] = lk_tx_byte;
        lk_tx_take = 1'b1;
        cyc(1);
        lk_tx_take = 1'b0;
        d[7:0] = lk_tx_byte;
        stop_frame();
    endtask
endmodule // pmrb_link_master
`default_nettype wire

// ### dv/power_monitor_register_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
module power_monitor_register_bank_tb;
    localparam logic [15:0] MAKER = 16'h3C5A; // arbitrary value
    localparam logic [15:0] DIE = 16'h0A17; // arbitrary value
    // short conversion counts keep the run small
    localparam int CONV [8] = '{8, 10, 12, 14, 16, 18, 20, 22};
    localparam logic [15:0] SENSE = 16'h0100;
    localparam logic [15:0] RAIL = 16'h1000;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] sense_sample = 16'h0000;
    logic [15:0] rail_sample = 16'h0000;
    logic [15:0] setup_word, alert_sel_word, alert_limit_word, got;
    logic conv_busy, link_clk, lk_wr_start, lk_rx_valid, lk_rd_start, lk_tx_take, lk_stop, lk_tx_ready;
    logic [7:0] lk_rx_byte, lk_tx_byte;
    int bad_count = 0;
    int n_checks = 0;
    always #4 mclk = ~mclk;
    pmrb_bank #(.MAKER_CODE(MAKER), .DIE_CODE(DIE), .CONV_CYC(CONV)) DUT (.mclk(mclk), .rst_n(rst_n),
        .sense_sample(sense_sample), .rail_sample(rail_sample), .setup_word(setup_word),
        .alert_sel_word(alert_sel_word), .alert_limit_word(alert_limit_word), .conv_busy(conv_busy),
        .link_clk(link_clk), .lk_wr_start(lk_wr_start), .lk_rx_valid(lk_rx_valid), .lk_rx_byte(lk_rx_byte),
        .lk_rd_start(lk_rd_start), .lk_tx_take(lk_tx_take), .lk_stop(lk_stop), .lk_tx_byte(lk_tx_byte),
        .lk_tx_ready(lk_tx_ready));
    pmrb_link_master pm (.link_clk(link_clk), .lk_wr_start(lk_wr_start), .lk_rx_valid(lk_rx_valid),
        .lk_rx_byte(lk_rx_byte), .lk_rd_start(lk_rd_start), .lk_tx_take(lk_tx_take), .lk_stop(lk_stop),
        .lk_tx_byte(lk_tx_byte), .lk_tx_ready(lk_tx_ready));
    task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        pm.wr_word(p, d, 1'b0);
    endtask
    // setp low reads again through the pointer left by the last write
    task automatic rd(input logic [7:0] p, input logic [15:0] exp, input bit setp);
        if (setp) pm.wr_word(p, 16'h0000, 1'b1);
        pm.rd_word(got);
        if (pm.hung) begin
            bad_count++;
            final_report();
        end
        cmp16($sformatf("reg %h", p), exp, got);
    endtask
    initial begin
        int i;
        logic [15:0] w;
        // link side resets through a synchroniser, so its clock must run during reset
        fork
            repeat (10) @(posedge mclk);
            pm.cyc(4);
        join
        @(posedge mclk);
        rst_n <= 1'b1;
        sense_sample <= SENSE;
        rail_sample <= RAIL;
        // offset the link clock from mclk so neither edge lands on the other
        #3.3;
        pm.cyc(3);
        cmp16("setup port", 16'h4127, setup_word);
        rd(8'h00, 16'h4127, 1);
        rd(8'h01, SENSE, 1);
        rd(8'h02, RAIL, 1);
        rd(8'h03, 16'h0000, 1);
        rd(8'h04, 16'h0000, 1);
        rd(8'h05, 16'h0000, 1);
        rd(8'h07, 16'h0000, 1);
        rd(8'hFE, MAKER, 1);
        rd(8'hFF, DIE, 1);
        cmp16("alert sel port", 16'h0000, alert_sel_word);
        $display("test reset_values done");
        wr(8'h05, 16'h0800);
        wr(8'h07, 16'hABCD);
        wr(8'h06, 16'hFFFF);
        cmp16("alert sel port", 16'hFC03, alert_sel_word);
        cmp16("limit port", 16'hABCD, alert_limit_word);
        rd(8'h05, 16'h0800, 1);
        rd(8'h04, 16'h0100, 1);
        rd(8'h03, 16'h0034, 1);
        $display("test read_write done");
        wr(8'h01, 16'hFFFF);
        wr(8'h04, 16'hFFFF);
        wr(8'h10, 16'h1234);
        wr(8'hFE, 16'h0000);
        rd(8'h01, SENSE, 1);
        rd(8'h04, 16'h0100, 1);
        rd(8'h10, 16'h0000, 1);
        rd(8'hFE, MAKER, 1);
        cmp16("setup port", 16'h4127, setup_word);
        $display("test refused_writes done");
        for (i = 0; i < 8; i++) begin
            w = {4'h4, i[2:0], i[2:0], i[2:0], i[2:0]};
            wr(8'h00, w);
            cmp16("setup port", w, setup_word);
            rd(8'h00, w, 1);
            rd(8'h00, w, 0);
            if (w[1:0] == 2'b00) cmp16("busy port", 16'h0000, 16'(conv_busy));
            if (i == 0) rd(8'h06, 16'hFC03, 1);
        end
        $display("test setup_fields done");
        wr(8'h00, 16'h8000);
        cmp16("setup port", 16'h4127, setup_word);
        cmp16("limit port", 16'h0000, alert_limit_word);
        cmp16("alert sel port", 16'h0000, alert_sel_word);
        rd(8'h00, 16'h4127, 0);
        rd(8'h05, 16'h0000, 1);
        $display("test soft_reset done");
        final_report();
    end
endmodule // power_monitor_register_bank_tb
`default_nettype wire
